// File: dv/pin_partner.sv
`timescale 1ns/100ps
`default_nettype none
module pin_partner #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic [W-1:0] pin_oe_r,
   input  wire logic [W-1:0] pin_out_r,
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   output logic      [W-1:0] pin_in
);
   logic [W-1:0] float_r = '0;
   // nobody drives: toggle so a stale level never passes for data
   always_ff @(posedge clock) begin
      float_r <= ~pin_in;
   end
   always_comb begin
      pin_in = (pin_oe_r & pin_out_r) | (~pin_oe_r & ext_en & ext_val)
             | (~pin_oe_r & ~ext_en & float_r);
   end
endmodule
`default_nettype wire

// File: dv/test_port_alt_pad_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_port_alt_pad_ctrl;
   import pad_ctrl_pkg::*;
   logic        clock;
   logic        reset_n;
   logic [15:0] sfr_addr;
   logic        sfr_wr;
   logic        sfr_rd;
   logic        sfr_byte;
   logic [15:0] sfr_wdata;
   logic [15:0] sfr_rdata_r;
   logic [7:0]  alt_out_en;
   logic [7:0]  alt_out_data;
   logic [7:0]  alt_out_pwm;
   logic [7:0]  auto_dir_en;
   logic [7:0]  auto_dir_out;
   logic        seg_enable;
   logic [7:0]  seg_addr;
   logic [7:0]  pin_in;
   logic [7:0]  pin_out_r;
   logic [7:0]  pin_oe_r;
   logic [7:0]  alt_in_r;
   wire  [7:0]  pads;
   logic [7:0]  ext_en;
   logic [7:0]  ext_val;
   logic [15:0] got;
   logic [7:0]  codes [4] = '{8'hE4, 8'h1B, 8'h4E, 8'hB1};
   int          failures = 0;
   int          checked = 0;
   int          cycles = 0;

   port_alt_pad_ctrl #(.LINES(8), .SEG_PORT(1'b1),
      .RESET_AUTO_MASK(8'h40)) i_dut (
      .clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_byte(sfr_byte),
      .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
      .alt_out_en(alt_out_en), .alt_out_data(alt_out_data),
      .alt_out_pwm(alt_out_pwm), .auto_dir_en(auto_dir_en),
      .auto_dir_out(auto_dir_out), .seg_enable(seg_enable),
      .seg_addr(seg_addr), .pin_in(pin_in), .pin_out_r(pin_out_r),
      .pin_oe_r(pin_oe_r), .alt_in_r(alt_in_r),
      .rw_strobe_edge_sel(pads[1:0]), .rw_strobe_drive_sel(pads[3:2]),
      .latch_strobe_edge_sel(pads[5:4]),
      .latch_strobe_drive_sel(pads[7:6]));

   pin_partner #(.W(8)) i_partner (
      .clock(clock), .pin_oe_r(pin_oe_r), .pin_out_r(pin_out_r),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("summary: %0d compares, %0d mismatches", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic compare(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask

   // read data is registered: look just after the edge that takes the strobe
   task automatic rd(input logic [15:0] a, input logic b,
                     output logic [15:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_byte <= b;
      sfr_rd <= 1'b1;
      @(posedge clock);
      sfr_rd <= 1'b0;
      sfr_byte <= 1'b0;
      #1 d = sfr_rdata_r;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, sfr_byte} = '0;
      {alt_out_en, alt_out_data, alt_out_pwm, auto_dir_en} = '0;
      {auto_dir_out, seg_enable, seg_addr, ext_en, ext_val} = '0;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      settle(1);
      compare({8'h00, pads}, {8'h00, STROBE_PAD_RESET});
      compare({8'h00, pin_oe_r}, 16'h0000);
      rd(STROBE_PAD_CTRL_ADDR, 1'b0, got);
      compare(got, 16'h0000);
      rd(PORT_DIR_ADDR, 1'b0, got);
      compare(got, PORT_DIR_RESET);
      $display("test reset done");
      // each field walks through every code, reserved ones too
      foreach (codes[i]) begin
         wr(STROBE_PAD_CTRL_ADDR, {8'hFF, codes[i]});
         settle(0);
         compare({8'h00, pads}, {8'h00, codes[i]});
         rd(STROBE_PAD_CTRL_ADDR, 1'b0, got);
         compare(got, {8'h00, codes[i]});
         rd(STROBE_PAD_CTRL_ADDR, 1'b1, got);
         compare(got, {8'h00, codes[i]});
      end
      // unmapped address: read gives zero, write leaves the pads alone
      rd(16'hF0AC, 1'b0, got);
      compare(got, 16'h0000);
      wr(16'hF0AC, 16'h00FF);
      settle(0);
      compare({8'h00, pads}, {8'h00, codes[3]});
      $display("test pad register done");
      @(posedge clock);
      ext_en <= 8'hFC;
      ext_val <= 8'h94;
      wr(PORT_LATCH_ADDR, 16'h000F);
      @(posedge clock);
      wr(PORT_DIR_ADDR, 16'h0003);
      settle(3);
      compare({pin_oe_r, pin_out_r}, 16'h030F);
      compare({8'h00, alt_in_r}, 16'h0097);
      rd(PORT_LATCH_ADDR, 1'b1, got);
      compare(got, 16'h000F);
      rd(PORT_DIR_ADDR, 1'b1, got);
      compare(got, 16'h0003);
      $display("test gpio done");
      @(posedge clock);
      alt_out_en <= 8'hFF;
      alt_out_data <= 8'hAA;
      alt_out_pwm <= 8'h80;
      settle(2);
      compare({pin_oe_r, pin_out_r}, 16'h438A);
      // line 0 now drives low, yet its alternate input must see the latch
      compare({8'h00, alt_in_r}, 16'h0097);
      @(posedge clock);
      auto_dir_en <= 8'h30;
      auto_dir_out <= 8'h10;
      settle(2);
      compare({pin_oe_r, pin_out_r}, 16'h53AA);
      @(posedge clock);
      seg_enable <= 1'b1;
      seg_addr <= 8'h5A;
      settle(2);
      compare({pin_oe_r, pin_out_r}, 16'hFF5A);
      $display("test alternate functions done");
      // reset with non-zero pad codes and output lines: all must clear
      @(posedge clock);
      reset_n <= 1'b0;
      {alt_out_en, auto_dir_en, seg_enable} <= '0;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      settle(1);
      compare({8'h00, pads}, {8'h00, STROBE_PAD_RESET});
      compare({8'h00, pin_oe_r}, 16'h0000);
      rd(PORT_DIR_ADDR, 1'b0, got);
      compare(got, PORT_DIR_RESET);
      rd(STROBE_PAD_CTRL_ADDR, 1'b0, got);
      compare(got, 16'h0000);
      $display("test mid-run reset done");
      end_of_test();
   end
endmodule
`default_nettype wire

// File: src/pad_ctrl_pkg.sv
package pad_ctrl_pkg;

   // register addresses in the extended special-function space
   localparam logic [15:0] STROBE_PAD_CTRL_ADDR = 16'hF0AA;
   localparam logic [15:0] PORT_LATCH_ADDR      = 16'hFE00;
   localparam logic [15:0] PORT_DIR_ADDR        = 16'hFE02;

   // reset values
   localparam logic [7:0]  STROBE_PAD_RESET     = 8'h00;
   localparam logic [15:0] PORT_LATCH_RESET     = 16'h0000;
   localparam logic [15:0] PORT_DIR_RESET       = 16'h0000;

   // field positions inside the strobe pad control register
   localparam int RW_EDGE_LSB     = 0;
   localparam int RW_DRIVE_LSB    = 2;
   localparam int LATCH_EDGE_LSB  = 4;
   localparam int LATCH_DRIVE_LSB = 6;
   localparam int PAD_FIELD_W     = 2;
   localparam int PAD_CTRL_W      = 8;

   // edge characteristic encodings; 2 and 3 are reserved
   localparam logic [1:0] EDGE_FAST     = 2'h0;
   localparam logic [1:0] EDGE_SLOW     = 2'h1;
   // driver characteristic encodings; 3 is reserved
   localparam logic [1:0] DRIVE_HIGH    = 2'h0;
   localparam logic [1:0] DRIVE_DYNAMIC = 2'h1;
   localparam logic [1:0] DRIVE_LOW     = 2'h2;

endpackage

// File: src/port_alt_pad_ctrl.sv
//Contract
//- strobe pad register, read/write, resets zero
//- edge field: 00 fast, 01 slow
//- drive field: 00 high, 01 dynamic, 10 low
//- alternate output only when direction is one, unless the line self-configures at reset or hardware sets its direction
//- pin drives latch AND alternate data, not PWM
//- direction bits reset to input
//- line with direction one and no hardware direction loops latch to alternate input
//- bus lines switch direction by hardware
//- reset-time alternate outputs self-configure direction
//- one alternate function per line, else GPIO
//- segmentation puts A16..A23 on port lines
//- high byte of pad register reads zero
`timescale 1ns/100ps
`default_nettype none
module port_alt_pad_ctrl
   import pad_ctrl_pkg::*;
#(
   parameter int              LINES           = 8,
   parameter bit              SEG_PORT        = 1'b1,
   parameter logic [LINES-1:0] RESET_AUTO_MASK = '0
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [15:0]      sfr_addr,
   input  wire logic             sfr_wr,
   input  wire logic             sfr_rd,
   input  wire logic             sfr_byte,
   input  wire logic [15:0]      sfr_wdata,
   output logic      [15:0]      sfr_rdata_r,
   input  wire logic [LINES-1:0] alt_out_en,
   input  wire logic [LINES-1:0] alt_out_data,
   input  wire logic [LINES-1:0] alt_out_pwm,
   input  wire logic [LINES-1:0] auto_dir_en,
   input  wire logic [LINES-1:0] auto_dir_out,
   input  wire logic             seg_enable,
   input  wire logic [LINES-1:0] seg_addr,
   input  wire logic [LINES-1:0] pin_in,
   output logic      [LINES-1:0] pin_out_r,
   output logic      [LINES-1:0] pin_oe_r,
   output logic      [LINES-1:0] alt_in_r,
   output logic      [1:0]       rw_strobe_edge_sel,
   output logic      [1:0]       rw_strobe_drive_sel,
   output logic      [1:0]       latch_strobe_edge_sel,
   output logic      [1:0]       latch_strobe_drive_sel
);

   ////////////////////////////////////////////////////////////////////////
   // register file

   logic [PAD_CTRL_W-1:0] strobe_pad_ctrl_reg_r;
   logic [PAD_CTRL_W-1:0] strobe_pad_ctrl_reg_nxt;
   logic [LINES-1:0]      latch_r;
   logic [LINES-1:0]      latch_nxt;
   logic [LINES-1:0]      line_direction_bit_r;
   logic [LINES-1:0]      line_direction_bit_nxt;
   logic [15:0]           rdata_nxt;
   logic [15:0]           wmask;
   logic [15:0]           latch_wide;
   logic [15:0]           dir_wide;
   logic                  hit_pad;
   logic                  hit_latch;
   logic                  hit_dir;

   always_comb begin
      hit_pad   = (sfr_addr == STROBE_PAD_CTRL_ADDR);
      hit_latch = (sfr_addr == PORT_LATCH_ADDR);
      hit_dir   = (sfr_addr == PORT_DIR_ADDR);
      // byte access touches only the low byte
      wmask      = sfr_byte ? 16'h00FF : 16'hFFFF;
      latch_wide = 16'(latch_r);
      dir_wide   = 16'(line_direction_bit_r);
      strobe_pad_ctrl_reg_nxt = strobe_pad_ctrl_reg_r;
      latch_nxt               = latch_r;
      line_direction_bit_nxt  = line_direction_bit_r;
      if (sfr_wr && hit_pad) begin
         // reserved encodings are stored as written
         strobe_pad_ctrl_reg_nxt = sfr_wdata[PAD_CTRL_W-1:0];
      end
      if (sfr_wr && hit_latch) begin
         latch_nxt = LINES'((latch_wide & ~wmask) | (sfr_wdata & wmask));
      end
      if (sfr_wr && hit_dir) begin
         line_direction_bit_nxt =
            LINES'((dir_wide & ~wmask) | (sfr_wdata & wmask));
      end
      rdata_nxt = 16'h0000;
      if (sfr_rd) begin
         if (hit_pad) begin
            // upper byte is always zero
            rdata_nxt = {8'h00, strobe_pad_ctrl_reg_r};
         end else if (hit_latch) begin
            rdata_nxt = latch_wide & wmask;
         end else if (hit_dir) begin
            rdata_nxt = dir_wide & wmask;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         strobe_pad_ctrl_reg_r <= STROBE_PAD_RESET;
         latch_r               <= LINES'(PORT_LATCH_RESET);
         line_direction_bit_r  <= LINES'(PORT_DIR_RESET);
         sfr_rdata_r           <= 16'h0000;
      end else begin
         strobe_pad_ctrl_reg_r <= strobe_pad_ctrl_reg_nxt;
         latch_r               <= latch_nxt;
         line_direction_bit_r  <= line_direction_bit_nxt;
         sfr_rdata_r           <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pad characteristics, static from the register

   // fields reach the pads on the edge that stores the write
   assign rw_strobe_edge_sel =
      strobe_pad_ctrl_reg_r[RW_EDGE_LSB +: PAD_FIELD_W];
   assign rw_strobe_drive_sel =
      strobe_pad_ctrl_reg_r[RW_DRIVE_LSB +: PAD_FIELD_W];
   assign latch_strobe_edge_sel =
      strobe_pad_ctrl_reg_r[LATCH_EDGE_LSB +: PAD_FIELD_W];
   assign latch_strobe_drive_sel =
      strobe_pad_ctrl_reg_r[LATCH_DRIVE_LSB +: PAD_FIELD_W];

   ////////////////////////////////////////////////////////////////////////
   // port lines

   logic [LINES-1:0] eff_auto_en;
   logic [LINES-1:0] eff_auto_dir;
   logic [LINES-1:0] eff_alt_data;
   logic [LINES-1:0] drive_nxt;
   logic [LINES-1:0] oe_nxt;
   logic [LINES-1:0] alt_in_nxt;
   logic             seg_on;

   always_comb begin
      // segment address lines behave like bus lines: hardware owns them
      seg_on       = SEG_PORT && seg_enable;
      eff_auto_en  = seg_on ? {LINES{1'b1}} : auto_dir_en;
      eff_auto_dir = seg_on ? {LINES{1'b1}} : auto_dir_out;
      eff_alt_data = seg_on ? seg_addr : alt_out_data;
   end

   genvar g;
   generate
      for (g = 0; g < LINES; g++) begin : g_line
         port_line_mux u_line (
            .line_latch (latch_r[g]),
            .line_dir   (line_direction_bit_r[g]),
            .alt_en     (alt_out_en[g]),
            .alt_data   (eff_alt_data[g]),
            .alt_pwm    (alt_out_pwm[g]),
            .reset_auto (RESET_AUTO_MASK[g]),
            .auto_en    (eff_auto_en[g]),
            .auto_dir   (eff_auto_dir[g]),
            .pin_level  (pin_in[g]),
            .drive_nxt  (drive_nxt[g]),
            .oe_nxt     (oe_nxt[g]),
            .alt_in_nxt (alt_in_nxt[g])
         );
      end
   endgenerate

   // registered pins keep glitches off the pads at the cost of one cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pin_out_r <= '0;
         pin_oe_r  <= '0;
         alt_in_r  <= '0;
      end else begin
         pin_out_r <= drive_nxt;
         pin_oe_r  <= oe_nxt;
         alt_in_r  <= alt_in_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic [LINES-1:0] exp_and;
   logic [LINES-1:0] sw_gated;
   always_comb begin
      exp_and  = (latch_r & alt_out_data) | (alt_out_pwm & alt_out_data);
      sw_gated = alt_out_en & ~eff_auto_en & ~RESET_AUTO_MASK;
   end

   sequence s_pad_write;
      sfr_wr && hit_pad;
   endsequence

   sequence s_pad_read;
      sfr_rd && hit_pad;
   endsequence

   chk_pad_reset_zero: assert property (@(posedge clock)
      $rose(reset_n) |-> strobe_pad_ctrl_reg_r == STROBE_PAD_RESET)
      else $error("pad control not zero after reset");

   chk_pad_write_fields: assert property (@(posedge clock)
      disable iff (!reset_n)
      s_pad_write |=> {latch_strobe_drive_sel, latch_strobe_edge_sel,
                       rw_strobe_drive_sel, rw_strobe_edge_sel}
                      == $past(sfr_wdata[7:0]))
      else $error("pad fields did not follow write");

   chk_pad_high_zero: assert property (@(posedge clock)
      disable iff (!reset_n)
      s_pad_read |=> sfr_rdata_r[15:8] == 8'h00
                     && sfr_rdata_r[7:0] == $past(strobe_pad_ctrl_reg_r))
      else $error("pad read returned wrong value");

   chk_dir_reset_input: assert property (@(posedge clock)
      $rose(reset_n) |-> line_direction_bit_r == '0 && pin_oe_r == '0)
      else $error("direction not input after reset");

   chk_oe_gate_dir: assert property (@(posedge clock)
      disable iff (!reset_n)
      (sw_gated & ~line_direction_bit_r) != '0 |=>
         (pin_oe_r & $past(sw_gated & ~line_direction_bit_r)) == '0)
      else $error("alternate output drove an input line");

   chk_and_latch_data: assert property (@(posedge clock)
      disable iff (!reset_n)
      1'b1 |=> ((pin_out_r ^ $past(exp_and)) & $past(sw_gated)) == '0)
      else $error("alternate output not ANDed with latch");

   chk_latch_loopback: assert property (@(posedge clock)
      disable iff (!reset_n)
      1'b1 |=> ((alt_in_r ^ $past(latch_r))
                & $past(line_direction_bit_r & ~eff_auto_en)) == '0)
      else $error("alternate input missed latch loopback");

   chk_auto_direction: assert property (@(posedge clock)
      disable iff (!reset_n)
      1'b1 |=> ((pin_oe_r ^ $past(eff_auto_dir)) & $past(eff_auto_en)) == '0)
      else $error("hardware direction not applied");

   chk_segment_out: assert property (@(posedge clock)
      disable iff (!reset_n)
      (SEG_PORT && seg_enable) |=> pin_oe_r == '1
                                   && pin_out_r == $past(seg_addr))
      else $error("segment address not on pins");

endmodule
`default_nettype wire

// File: src/port_line_mux.sv
`timescale 1ns/100ps
`default_nettype none
module port_line_mux (
   input  wire logic line_latch,
   input  wire logic line_dir,
   input  wire logic alt_en,
   input  wire logic alt_data,
   input  wire logic alt_pwm,
   input  wire logic reset_auto,
   input  wire logic auto_en,
   input  wire logic auto_dir,
   input  wire logic pin_level,
   output logic      drive_nxt,
   output logic      oe_nxt,
   output logic      alt_in_nxt
);

   always_comb begin
      // hardware direction first, then auto-configured outputs, then software
      if (auto_en) begin
         oe_nxt = auto_dir;
      end else if (alt_en && reset_auto) begin
         oe_nxt = 1'b1;
      end else begin
         oe_nxt = line_dir;
      end
      if (auto_en) begin
         drive_nxt = alt_data;
      end else if (alt_en) begin
         // latch must hold one for non-PWM alternate data to pass
         drive_nxt = alt_pwm ? alt_data : (line_latch & alt_data);
      end else begin
         drive_nxt = line_latch;
      end
      // a line with direction one and no hardware direction feeds its own latch back to the alternate input
      alt_in_nxt = (line_dir && !auto_en) ? line_latch : pin_level;
   end

endmodule
`default_nettype wire
